// ==== hdl/rtcts_pkg.sv ====
// Notes on behaviour
// - Time-count correction alters one-second tick length once every twenty seconds.
// - Trim codes 0, +1, -64 and -63 apply no correction at all.
// - Trim is 7-bit signed; a negative value is stored as 128 minus magnitude.
// - Positive codes slow the count in proportion to their distance above 01h.
// - Negative codes speed the count in proportion to their distance below 80h.
// - Codes 02h to 3Fh retard timekeeping, correcting a fast oscillator.
// - Codes 7Fh down to 42h advance timekeeping, correcting a slow oscillator.
// - The free-running sub clock output never depends on the trim setting.
// - Halt flag is sticky until the host writes zero; low-supply flag until a zero write or a halt event.
// - Supply threshold is 2.1 V when select is zero (default), 1.6 V when one.
// - Setting the halt flag clears the low-supply flag.
// - Halt flag setting clears trim, threshold select, low flag and other control bits.
// - The halt flag is set at power-on from zero volts.
// - Supply is sampled only during a 7.8 ms window once per second.
// - Sampling stops while the low-supply flag is set.
package rtcts_pkg;

  // Timing of the system clock and the supply sampling window.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SAMPLE_WIN_NS  = 7800000;
  localparam int unsigned SAMPLE_WIN_CYC = SAMPLE_WIN_NS / CLK_PERIOD_NS;

  // Oscillator cycles per nominal second and the corrected second index.
  localparam logic [16:0] SEC_CYCLES    = 17'h08000;
  localparam logic [4:0]  CORR_LAST_SEC = 5'h13;

  // Trim code landmarks.
  localparam logic [6:0]  TRIM_POS_BASE = 7'h01;
  localparam logic [6:0]  TRIM_POS_MIN  = 7'h02;
  localparam logic [6:0]  TRIM_POS_MAX  = 7'h3f;
  localparam logic [6:0]  TRIM_NEG_MIN  = 7'h42;
  localparam logic [7:0]  TRIM_NEG_BASE = 8'h80;

  // Values after reset.
  localparam logic [6:0]  TRIM_RST = 7'h00;
  localparam logic        HALT_RST = 1'b1;
  localparam logic        LOW_RST  = 1'b0;
  localparam logic        VSEL_RST = 1'b0;
  localparam logic        CLR_RST  = 1'b1;

  // Signed cycle adjustment of the corrected second for a trim code.
  function automatic logic signed [7:0] rtcts_trim_adjust(input logic [6:0] code);
    logic signed [7:0] adj;
    adj = 8'sh00;
    if (code >= TRIM_POS_MIN && code <= TRIM_POS_MAX) begin
      adj = $signed({1'b0, code - TRIM_POS_BASE});
    end else if (code >= TRIM_NEG_MIN) begin
      adj = -$signed(TRIM_NEG_BASE - {1'b0, code});
    end
    // disabled codes fall through to zero.
    return adj;
  endfunction : rtcts_trim_adjust

endpackage : rtcts_pkg

// ==== hdl/rtcts_tick_if.sv ====
`timescale 1ns/10ps
// Carries the trim value to the prescaler and the second tick back.
interface rtcts_tick_if;
  logic [6:0] trim;
  logic       second_tick;

  modport status    (output trim, input second_tick);
  modport prescaler (input trim, output second_tick);
endinterface : rtcts_tick_if

// ==== hdl/rtcts_second_prescaler.sv ====
`timescale 1ns/10ps
module rtcts_second_prescaler
  import rtcts_pkg::*;
#(
  parameter int unsigned SEC_EDGES = SEC_CYCLES
)
(
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Oscillator level and free-running copy.
  input  wire logic       osc_level_i,
  output logic            sub_clock_output_o,
  // Link to the status logic.
  rtcts_tick_if.prescaler tk
);

  typedef struct packed {
    logic        osc_prev;
    logic        sub_clk;
    logic [16:0] cyc;
    logic [4:0]  sec;
    logic        tick;
  } rtcts_presc_s;

  localparam rtcts_presc_s PRESC_RST = '0;
  localparam logic [16:0]  SEC_LEN   = 17'(SEC_EDGES);

  rtcts_presc_s      cur;
  rtcts_presc_s      next_st;
  logic signed [7:0] adj;
  logic [16:0]       period;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: count oscillator edges and lengthen or shorten every twentieth second.
  always_comb begin
    next_st          = cur;
    next_st.osc_prev = osc_level_i;
    // sub clock is a plain copy
    next_st.sub_clk  = osc_level_i;
    next_st.tick     = 1'b0;
    adj              = rtcts_trim_adjust(tk.trim);
    period = (cur.sec == CORR_LAST_SEC) ? SEC_LEN + {{9{adj[7]}}, adj} : SEC_LEN;
    if (osc_level_i && !cur.osc_prev) begin
      // The >= guards against a trim shrinking the period mid-count.
      if (cur.cyc >= period - 17'h00001) begin
        next_st.cyc  = '0;
        next_st.tick = 1'b1;
        next_st.sec  = (cur.sec == CORR_LAST_SEC) ? 5'h00 : cur.sec + 5'h01;
      end else begin
        next_st.cyc = cur.cyc + 17'h00001;
      end
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur <= PRESC_RST;
    end else begin
      cur <= next_st;
    end
  end

  assign sub_clock_output_o = cur.sub_clk;
  assign tk.second_tick     = cur.tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Independent edge tally used only by the checks below.
  logic [16:0] h_edges;
  logic [4:0]  h_secs;
  logic        h_trim_chg;
  logic [6:0]  h_trim_prev;
  logic signed [7:0] h_adj;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h_edges     <= '0;
      h_secs      <= '0;
      h_trim_chg  <= 1'b0;
      h_trim_prev <= TRIM_RST;
    end else begin
      h_trim_prev <= tk.trim;
      if (cur.tick) begin
        h_edges    <= (osc_level_i && !cur.osc_prev) ? 17'h00001 : 17'h00000;
        h_secs     <= (h_secs == CORR_LAST_SEC) ? 5'h00 : h_secs + 5'h01;
        h_trim_chg <= 1'b0;
      end else begin
        if (osc_level_i && !cur.osc_prev) begin
          h_edges <= h_edges + 17'h00001;
        end
        if (tk.trim != h_trim_prev) begin
          h_trim_chg <= 1'b1;
        end
      end
    end
  end

  // Trim that was in force at the edge that closed the second.
  assign h_adj = rtcts_trim_adjust(h_trim_prev);

  a_second_length: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (cur.tick && !h_trim_chg) |-> h_edges == ((h_secs == CORR_LAST_SEC) ?
      SEC_LEN + {{9{h_adj[7]}}, h_adj} : SEC_LEN))
    else $error("Second length does not match trim");

  a_disabled_trim: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (cur.tick && !h_trim_chg && (h_trim_prev == 7'h00 || h_trim_prev == 7'h01 ||
      h_trim_prev == 7'h40 || h_trim_prev == 7'h41)) |-> h_edges == SEC_LEN)
    else $error("Disabled trim code changed the second");

  // sub clock check, skipping the edge that still saw reset
  a_sub_clock_free: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) |-> sub_clock_output_o == $past(osc_level_i))
    else $error("Sub clock output does not follow oscillator");

endmodule : rtcts_second_prescaler

// ==== hdl/rtcts_status.sv ====
`timescale 1ns/10ps
module rtcts_status
  import rtcts_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_WIN_CYC,
  parameter int unsigned SEC_EDGES     = SEC_CYCLES
)
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Oscillator and its free-running copy.
  input  wire logic        osc_level_i,
  input  wire logic        osc_stop_i,
  output logic             sub_clock_output_o,
  output logic             second_tick_o,
  // Trim setting from the host.
  input  wire logic        trim_wr_i,
  input  wire logic [6:0]  trim_wdata_i,
  output logic [6:0]       trim_o,
  // Supply threshold select from the host.
  input  wire logic        threshold_wr_i,
  input  wire logic        threshold_wdata_i,
  output logic             supply_threshold_select_o,
  // Supply comparator.
  input  wire logic        supply_below_i,
  output logic             supply_sample_en_o,
  // Status flags and their host writes.
  input  wire logic        halt_flag_wr_i,
  input  wire logic        halt_flag_wdata_i,
  input  wire logic        low_flag_wr_i,
  input  wire logic        low_flag_wdata_i,
  output logic             osc_halt_flag_o,
  output logic             low_supply_flag_o,
  // Clear of the control bits held outside this block.
  output logic             ctrl_clear_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and constants.

  typedef struct packed {
    logic        halt;
    logic        low;
    logic [6:0]  trim;
    logic        vsel;
    logic        win;
    logic [19:0] wcnt;
    logic        clr;
  } rtcts_stat_s;

  localparam rtcts_stat_s STAT_RST = '{
    halt: HALT_RST,
    low:  LOW_RST,
    trim: TRIM_RST,
    vsel: VSEL_RST,
    win:  1'b0,
    wcnt: 20'h00000,
    clr:  CLR_RST
  };

  localparam logic [19:0] WIN_LAST = 20'(SAMPLE_CYCLES - 1);

  rtcts_stat_s cur;
  rtcts_stat_s next_st;
  logic        low_set;

  rtcts_tick_if tk ();

  ////////////////////////////////////////////////////////////////////////////////
  // One-second prescaler with trim correction.

  rtcts_second_prescaler #(
    .SEC_EDGES (SEC_EDGES)
  ) u_prescaler (
    .clock_i            (clock_i),
    .rstn_i             (rstn_i),
    .osc_level_i        (osc_level_i),
    .sub_clock_output_o (sub_clock_output_o),
    .tk                 (tk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of flags, settings and the sampling window.

  always_comb begin
    next_st     = cur;
    // A supply drop only counts while the window is open.
    low_set     = cur.win && supply_below_i;
    next_st.clr = osc_stop_i;

    // Host settings take effect on the next edge.
    if (trim_wr_i) begin
      next_st.trim = trim_wdata_i;
    end
    if (threshold_wr_i) begin
      next_st.vsel = threshold_wdata_i;
    end

    if (halt_flag_wr_i && !halt_flag_wdata_i) begin
      next_st.halt = 1'b0;
    end
    if (osc_stop_i) begin
      next_st.halt = 1'b1;
    end

    if (low_flag_wr_i && !low_flag_wdata_i) begin
      next_st.low = 1'b0;
    end
    if (low_set) begin
      next_st.low = 1'b1;
    end

    if (tk.second_tick && !cur.low) begin
      next_st.win  = 1'b1;
      next_st.wcnt = 20'h00000;
    end else if (cur.win) begin
      if (cur.wcnt == WIN_LAST) begin
        next_st.win = 1'b0;
      end else begin
        next_st.wcnt = cur.wcnt + 20'h00001;
      end
    end

    if (osc_stop_i) begin
      next_st.low  = 1'b0;
      next_st.trim = TRIM_RST;
      next_st.vsel = VSEL_RST;
    end

    // no sampling while low flag set
    if (next_st.low) begin
      next_st.win = 1'b0;
    end
  end

  // State register; the halt flag comes up set after power-on.
  // halt set at power-on
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur <= STAT_RST;
    end else begin
      cur <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign tk.trim                   = cur.trim;
  assign trim_o                    = cur.trim;
  assign supply_threshold_select_o = cur.vsel;
  assign supply_sample_en_o        = cur.win;
  assign osc_halt_flag_o           = cur.halt;
  assign low_supply_flag_o         = cur.low;
  assign ctrl_clear_o              = cur.clr;
  assign second_tick_o             = tk.second_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the flag and window behaviour.

  a_halt_clears_ctl: assert property (@(posedge clock_i) disable iff (!rstn_i)
    osc_stop_i |=> (osc_halt_flag_o && trim_o == TRIM_RST && !supply_threshold_select_o
      && !low_supply_flag_o && ctrl_clear_o))
    else $error("Halt did not clear the control settings");

  a_halt_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (osc_halt_flag_o && !(halt_flag_wr_i && !halt_flag_wdata_i)) |=> osc_halt_flag_o)
    else $error("Halt flag dropped without a zero write");

  a_low_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (low_supply_flag_o && !osc_stop_i && !(low_flag_wr_i && !low_flag_wdata_i))
      |=> low_supply_flag_o)
    else $error("Low supply flag dropped without a zero write");

  a_halt_over_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(osc_halt_flag_o) |-> !low_supply_flag_o)
    else $error("Low supply flag set together with new halt");

  a_sample_suspend: assert property (@(posedge clock_i) disable iff (!rstn_i)
    low_supply_flag_o |-> !supply_sample_en_o)
    else $error("Sampling while low supply flag is set");

  a_window_open: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(supply_sample_en_o) |-> $past(second_tick_o))
    else $error("Sampling window opened away from a second tick");

  a_low_in_window: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(low_supply_flag_o) |-> $past(supply_sample_en_o && supply_below_i))
    else $error("Low supply flag set outside the window");

  a_thresh_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (threshold_wr_i && !osc_stop_i) |=> supply_threshold_select_o == $past(threshold_wdata_i))
    else $error("Threshold select did not take the written value");

endmodule : rtcts_status

// ==== testbench/rtcts_host_model.sv ====
`timescale 1ns/10ps
// Host side of the block: presents register writes and works out trim codes.
module rtcts_host_model (
  // Clock.
  input  wire logic clock_i,
  // Write strobes and data.
  output logic       trim_wr_o,
  output logic [6:0] trim_wdata_o,
  output logic       threshold_wr_o,
  output logic       threshold_wdata_o,
  output logic       halt_flag_wr_o,
  output logic       halt_flag_wdata_o,
  output logic       low_flag_wr_o,
  output logic       low_flag_wdata_o
);
  localparam int TARGET_CHZ = 3276805; // Target in hundredths of a hertz.

  logic [13:0] w_q = 14'h0000;

  // All write lines come from one vector so a transfer changes them together.
  assign {trim_wr_o, trim_wdata_o, threshold_wr_o, threshold_wdata_o,
          halt_flag_wr_o, halt_flag_wdata_o, low_flag_wr_o, low_flag_wdata_o} = w_q;

  ////////////////////////////////////////////////////////////////////////////////
  // trim from frequency
  function automatic logic [6:0] calc_trim(input int meas_chz);
    int d;
    d = meas_chz - TARGET_CHZ;
    // A fast part adds one step, since codes one and zero both mean idle.
    if (d > 0) return 7'(d / 10 + 1);
    return 7'(128 + (d - 5) / 10);
  endfunction : calc_trim

  // Presents one write vector just after a rising edge.
  task automatic put(input logic [13:0] w);
    @(posedge clock_i);
    w_q <= w;
  endtask : put
endmodule : rtcts_host_model

// ==== testbench/rtcts_status_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench for the trim and supply flag block.
module rtcts_status_tb;
  // Fields of the host write vector.
  localparam logic [13:0] W_TRIM = 14'h2000;
  localparam logic [13:0] W_THR  = 14'h0020;
  localparam logic [13:0] D_THR  = 14'h0010;
  localparam logic [13:0] W_HALT = 14'h0008;
  localparam logic [13:0] D_HALT = 14'h0004;
  localparam logic [13:0] W_LOW  = 14'h0002;
  localparam int          LIMIT  = 30000;
  localparam int          SEC_LEN  = 64;
  localparam int          WIN_LEN  = 8;
  localparam int          OSC_HALF = 3;

  logic        clk;
  logic        rstn;
  logic        osc;
  logic        osc_stop;
  logic        below;
  logic        trim_wr, thr_wr, thr_wd, halt_wr, halt_wd, low_wr, low_wd;
  logic [6:0]  trim_wd, trim_q;
  logic        sub_clk, tick, thr_q, sample_en, halt_q, low_q, clr;
  logic [9:0]  exp_v;
  logic        exp_clr;
  logic [13:0] last_w;
  logic        last_stop;
  logic        osc_seen, rst_seen;
  logic        m_oprev, m_tick, m_win;
  int          m_cnt, m_sec, m_wcnt;
  int          error_cnt, checks_done, cycles, seed;

  ////////////////////////////////////////////////////////////////////////////////
  rtcts_host_model host (.clock_i(clk), .trim_wr_o(trim_wr), .trim_wdata_o(trim_wd),
    .threshold_wr_o(thr_wr), .threshold_wdata_o(thr_wd), .halt_flag_wr_o(halt_wr),
    .halt_flag_wdata_o(halt_wd), .low_flag_wr_o(low_wr), .low_flag_wdata_o(low_wd));

  rtcts_status #(.SAMPLE_CYCLES(WIN_LEN), .SEC_EDGES(SEC_LEN)) DUT (.clock_i(clk),
    .rstn_i(rstn), .osc_level_i(osc),
    .osc_stop_i(osc_stop), .sub_clock_output_o(sub_clk), .second_tick_o(tick),
    .trim_wr_i(trim_wr), .trim_wdata_i(trim_wd), .trim_o(trim_q),
    .threshold_wr_i(thr_wr), .threshold_wdata_i(thr_wd),
    .supply_threshold_select_o(thr_q), .supply_below_i(below),
    .supply_sample_en_o(sample_en), .halt_flag_wr_i(halt_wr),
    .halt_flag_wdata_i(halt_wd), .low_flag_wr_i(low_wr), .low_flag_wdata_i(low_wd),
    .osc_halt_flag_o(halt_q), .low_supply_flag_o(low_q), .ctrl_clear_o(clr));

  ////////////////////////////////////////////////////////////////////////////////
  // Next expected {halt, low, threshold, trim}; a supply drop in the window beats a
  // zero write, and a halt event overrides everything.
  function automatic logic [9:0] exp_step(input logic [9:0] cur, input logic [13:0] w,
                                          input logic stop, input logic lset);
    logic [9:0] n;
    n = cur;
    if (w[13]) n[6:0] = w[12:6];
    if (w[5]) n[7] = w[4];
    if (w[3] && !w[2]) n[9] = 1'b0;
    if (w[1] && !w[0]) n[8] = 1'b0;
    if (lset) n[8] = 1'b1;
    if (stop) n = 10'h200;
    return n;
  endfunction : exp_step

  // Oscillator cycles added to the twentieth second: distance above 01h or below 80h.
  function automatic int trim_steps(input logic [6:0] c);
    if (c >= 7'h02 && c <= 7'h3f) return int'(c) - 1;
    if (c >= 7'h42) return int'(c) - 128;
    return 0;
  endfunction : trim_steps

  // Advances the reference second counter, window and flags by one clock edge.
  task automatic model_step(input logic osc_s, input logic below_s);
    logic lset;
    logic tick_n;
    lset   = m_win && below_s;
    tick_n = 1'b0;
    if (osc_s && !m_oprev) begin
      if (m_cnt + 1 >= SEC_LEN + ((m_sec == 19) ? trim_steps(exp_v[6:0]) : 0)) begin
        m_cnt  = 0;
        m_sec  = (m_sec + 1) % 20;
        tick_n = 1'b1;
      end else begin
        m_cnt++;
      end
    end
    m_oprev = osc_s;
    if (m_tick && !exp_v[8]) begin
      m_win  = 1'b1;
      m_wcnt = 0;
    end else if (m_win) begin
      if (m_wcnt == WIN_LEN - 1) begin
        m_win = 1'b0;
      end else begin
        m_wcnt++;
      end
    end
    m_tick = tick_n;
    exp_v  = exp_step(exp_v, last_w, last_stop, lset);
    if (exp_v[8]) m_win = 1'b0;
  endtask : model_step

  // Compares a one-bit result.
  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask : chk1

  // Compares a trim code.
  task automatic chk7(input logic [6:0] got, input logic [6:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : chk7

  // Compares every registered output except the sub clock against the expectation.
  task automatic chk_all();
    chk7(trim_q, exp_v[6:0], "trim");
    chk1(thr_q, exp_v[7], "threshold select");
    chk1(low_q, exp_v[8], "low supply flag");
    chk1(halt_q, exp_v[9], "halt flag");
    chk1(clr, exp_clr, "control clear");
    chk1(sample_en, m_win, "sample window");
    chk1(tick, m_tick, "second tick");
  endtask : chk_all

  // One bus cycle: drive a write vector, stop and comparator, then check outputs.
  task automatic cyc(input logic [13:0] w, input logic stop, input logic low_v);
    host.put(w);
    model_step(osc, below);
    exp_clr = last_stop;
    osc_stop <= stop;
    below <= low_v;
    last_w = w;
    last_stop = stop;
    #1;
    chk_all();
  endtask : cyc

  // Holds one trim code for twenty-one seconds so the corrected second passes by.
  task automatic trim_run(input logic [6:0] code);
    cyc(W_TRIM | W_LOW | (14'(code) << 6), 1'b0, 1'b0);
    repeat (SEC_LEN * OSC_HALF * 2 * 21) cyc(14'h0000, 1'b0, 1'b0);
    $display("test trim run done");
  endtask : trim_run

  // Random cycles with occasional halt events.
  task automatic rnd(input int n);
    repeat (n) cyc(14'($random(seed)), ($random(seed) & 15) == 0, 1'($random(seed)));
  endtask : rnd

  // Holds reset for twelve cycles, checks the power-on state, then releases it.
  task automatic do_reset();
    host.put(14'h0000);
    rstn <= 1'b0;
    osc_stop <= 1'b0;
    below <= 1'b0;
    last_w = 14'h0000;
    last_stop = 1'b0;
    {m_oprev, m_tick, m_win} = 3'h0;
    {m_cnt, m_sec, m_wcnt} = '0;
    repeat (11) @(posedge clk);
    exp_v = 10'h200;
    exp_clr = 1'b1;
    #1;
    chk_all();
    @(posedge clk);
    rstn <= 1'b1;
    $display("test reset done");
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Oscillator level, OSC_HALF clocks per level.
  initial begin
    osc = 1'b0;
    forever begin
      repeat (OSC_HALF) @(posedge clk);
      osc <= ~osc;
    end
  end

  // The sub clock copy must follow the oscillator whatever the trim.
  always @(posedge clk) begin
    osc_seen = osc;
    rst_seen = rstn;
    #1;
    if (rst_seen && rstn) chk1(sub_clk, osc_seen, "sub clock");
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("ERROR %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    seed = 32'hda89;
    {rstn, osc_stop, below, error_cnt, checks_done, cycles} = '0;
    do_reset();
    cyc(W_LOW, 1'b0, 1'b1);
    cyc(W_HALT | D_HALT, 1'b0, 1'b0);
    cyc(W_HALT, 1'b0, 1'b1);
    cyc(W_TRIM | W_THR | D_THR | (14'(host.calc_trim(3276885)) << 6), 1'b0, 1'b1);
    cyc(W_TRIM | (14'h0057 << 6), 1'b0, 1'b0);
    cyc(W_TRIM | W_THR | D_THR | W_HALT | (14'h003f << 6), 1'b1, 1'b1);
    cyc(14'h0000, 1'b1, 1'b0);
    cyc(14'h0000, 1'b0, 1'b0);
    cyc(14'h0000, 1'b0, 1'b0);
    $display("test corners done");
    for (int c = 0; c < 128; c++) cyc(W_TRIM | (14'(c) << 6), 1'b0, 1'b1);
    $display("test trim codes done");
    rnd(400);
    $display("test random done");
    trim_run(host.calc_trim(3276885));
    trim_run(host.calc_trim(3276395));
    trim_run(7'h41);
    do_reset();
    rnd(100);
    $display("test random after reset done");
    tally_and_finish();
  end
endmodule : rtcts_status_tb
